/* File: hdl/pll_clk_pkg.sv */
// Constants and types for the clock select and low-power controller
package pll_clk_pkg;
    localparam int          CLK_MHZ      = 100;         // clk rate in MHz
    localparam int          PLL_LOCK_US  = 1000;        // Lock time, us
    localparam int          PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam logic [7:0]  IDX_PLLCON   = 8'h3A;       // Synthesizer control
    localparam logic [7:0]  IDX_CPUMODE  = 8'h3B;       // System clock control
    localparam logic [7:0]  IDX_STATUS   = 8'h3C;       // Status, read only
    localparam logic [7:0]  IDX_WAKEPRE  = 8'h3D;       // Wake prescaler
    localparam logic [7:0]  IDX_WAKETMR  = 8'h3E;       // Wake timer 1
    localparam logic [5:0]  PLLCON_RST   = 6'h00;       // Synthesizer reset value
    localparam logic [7:0]  CPUMODE_RST  = 8'h00;       // Clock control reset value
    localparam logic [7:0]  PRE_STOP_VAL = 8'hFF;       // Prescaler preload on stop
    localparam logic [7:0]  TMR_STOP_VAL = 8'h01;       // Timer preload on stop
    localparam int          WAKE_DIV     = 16;          // Reference divide in wake
    localparam logic [3:0]  SYN_DIV0     = 4'h4;        // 48 to 12 MHz
    localparam logic [3:0]  SYN_DIV1     = 4'h6;        // 48 to 8 MHz
    localparam logic [3:0]  SYN_DIV2     = 4'h8;        // 48 to 6 MHz
    localparam logic [3:0]  SYN_DIV3     = 4'h2;        // 48 to 24 MHz
    localparam int          MUL_SH_LO    = 2;           // x4 from 12 MHz
    localparam int          MUL_SH_HI    = 3;           // x8 from 6 MHz

    // Synthesizer control fields
    typedef struct packed {
        logic [1:0] syn_div;    // Divided clock ratio code
        logic       rsv;        // Reads zero
        logic       usb_src;    // 1: synthesizer output, 0: reference
        logic       pll_mode;   // 1: x8, 0: x4
        logic       pll_en;     // Synthesizer enable
    } pll_cfg_t;

    // System clock control fields, ratio in bits 7:6
    typedef struct packed {
        logic [1:0] phi_div;    // CPU clock ratio code
        logic [3:0] rsv;        // Reads zero
        logic       stab_sel;   // 1: software loads wake counts
        logic       sys_src;    // 1: divided clock, 0: reference
    } cpu_cfg_t;

    // Low-power states, Gray along run-stop-wake
    typedef enum logic [1:0] {
        LP_RUN  = 2'b00,
        LP_STOP = 2'b01,
        LP_WAKE = 2'b11,
        LP_WAIT = 2'b10
    } lp_state_t;
endpackage : pll_clk_pkg

/* File: hdl/pll_clock_select_low_power.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Clock source select, synthesizer model, CPU clock divider and stop/wait control
module pll_clock_select_low_power
    import pll_clk_pkg::*;
#(
    parameter int LOCK_CYC = PLL_LOCK_CYC   // Lock wait in clk cycles
)
(
    input  wire logic        clk,           // 100 MHz clock
    input  wire logic        nrst,          // Async reset, low
    input  wire logic        ce,            // Clock enable
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        osc_in_pin,    // Oscillator input
    output logic             osc_out_pin,   // Oscillator drive
    output logic             osc_run,       // Oscillator running
    input  wire logic        stop_instr,    // Stop executed, pulse
    input  wire logic        wait_instr,    // Wait executed, pulse
    input  wire logic        ext_irq,       // External or resume interrupt
    input  wire logic        any_irq,       // Any enabled interrupt
    output logic             phi,           // Internal CPU clock
    output logic             usb_func_clk,  // USB clock
    output logic             syn_clk,       // Divided USB clock
    output logic             pll_locked,    // Lock time elapsed
    output logic             pre_div16_sel, // Prescaler fed ref over 16
    output lp_state_t        lp_state       // Low-power state
);
    localparam int LW = $clog2(LOCK_CYC + 1);            // Lock counter width
    localparam int WW = $clog2(2 * WAKE_DIV);            // Wake divider width
    localparam logic [11:0] A_PLL = {2'h0, IDX_PLLCON, 2'b00};
    localparam logic [11:0] A_CPU = {2'h0, IDX_CPUMODE, 2'b00};
    localparam logic [11:0] A_STA = {2'h0, IDX_STATUS, 2'b00};
    localparam logic [11:0] A_PRE = {2'h0, IDX_WAKEPRE, 2'b00};
    localparam logic [11:0] A_TMR = {2'h0, IDX_WAKETMR, 2'b00};
    localparam logic [LW-1:0] LOCK_END = LW'(LOCK_CYC);
    localparam logic [WW-1:0] W16_END  = WW'(2 * WAKE_DIV - 1);

    pll_cfg_t        pll_ff;        // Synthesizer control
    cpu_cfg_t        cpu_ff;        // System clock control
    lp_state_t       st_ff;         // Low-power state
    lp_state_t       nxt_st;        // Next state
    logic            s1_ff;         // Pin sync stage 1
    logic            s2_ff;         // Pin sync stage 2
    logic            s3_ff;         // Edge history
    logic            osc_ff;        // Oscillator enable
    logic            osc_out_pin_ff;       // Oscillator drive
    logic     [15:0] hp_cnt_ff;     // Cycles in current half period
    logic     [15:0] hp_len_ff;     // Last half period length
    logic     [15:0] vco_cnt_ff;    // Synthesizer step counter
    logic   [LW-1:0] lock_cnt_ff;   // Lock wait counter
    logic            usb_ff;        // USB clock level
    logic      [3:0] syn_cnt_ff;    // Divided clock counter
    logic            syn_ff;        // Divided clock level
    logic      [3:0] phi_cnt_ff;    // CPU clock counter
    logic            phi_ff;        // CPU clock level
    logic            src_act_ff;    // Source in use
    logic      [1:0] phd_act_ff;    // CPU ratio in use
    logic      [1:0] syd_act_ff;    // Divided ratio in use
    logic   [WW-1:0] w16_cnt_ff;    // Ref over 16 counter
    logic      [7:0] pre_cnt_ff;    // Wake prescaler count
    logic      [7:0] pre_rld_ff;    // Wake prescaler reload
    logic      [7:0] tmr_cnt_ff;    // Wake timer 1 count
    logic     [31:0] rd_ff;         // Read data
    logic     [31:0] rd_mux;        // Read data select

    // Decode and handshake
    wire        hit_pll = (paddr == A_PLL);
    wire        hit_cpu = (paddr == A_CPU);
    wire        hit_sta = (paddr == A_STA);
    wire        hit_pre = (paddr == A_PRE);
    wire        hit_tmr = (paddr == A_TMR);
    wire        hit     = hit_pll | hit_cpu | hit_sta | hit_pre | hit_tmr;
    wire        acc     = psel & penable;
    wire        wr      = ce & acc & pwrite & hit;
    wire        setup   = ce & psel & ~penable;

    // Clock edges and ticks
    wire        ref_edge = osc_ff & (s2_ff ^ s3_ff);
    wire        pll_act  = pll_ff.pll_en & osc_ff;
    wire [15:0] vco_sh   = pll_ff.pll_mode ? (hp_len_ff >> MUL_SH_HI)
                                           : (hp_len_ff >> MUL_SH_LO);
    wire [15:0] vco_lim  = (vco_sh == 16'h0000) ? 16'h0000 : vco_sh - 16'h0001;
    wire        vco_tick = pll_act & (vco_cnt_ff >= vco_lim);
    wire        usb_tick = pll_ff.usb_src ? vco_tick : ref_edge;
    wire [3:0]  syn_rat  = (syd_act_ff == 2'b00) ? SYN_DIV0 :
                           (syd_act_ff == 2'b01) ? SYN_DIV1 :
                           (syd_act_ff == 2'b10) ? SYN_DIV2 : SYN_DIV3;
    wire        syn_tick = usb_tick & (syn_cnt_ff >= syn_rat - 4'h1);
    wire        sys_tick = src_act_ff ? syn_tick : ref_edge;
    wire [3:0]  phi_rat  = 4'h1 << phd_act_ff;
    wire        phi_step = sys_tick & (phi_cnt_ff >= phi_rat - 4'h1);
    wire        halt     = (st_ff != LP_RUN);
    wire        phi_tog  = phi_step & ~(halt & phi_ff);
    wire        phi_rise = phi_tog & ~phi_ff;
    wire        w16_tick = ref_edge & (w16_cnt_ff == W16_END);
    wire        wake_cnt = (st_ff == LP_WAKE) & w16_tick;
    wire        pre_zero = (pre_cnt_ff == 8'h00);
    wire        tmr_udf  = wake_cnt & pre_zero & (tmr_cnt_ff == 8'h00);
    wire        stop_go  = (st_ff == LP_RUN) & stop_instr;
    wire        preload  = stop_go & ~cpu_ff.stab_sel;

    // Read data select
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_pll)
        begin
            rd_mux[5:0] = pll_ff;
        end
        else if (hit_cpu)
        begin
            rd_mux[7:0] = cpu_ff;
        end
        else if (hit_sta)
        begin
            rd_mux[3:0] = {phi_ff, st_ff, pll_locked};
        end
        else if (hit_pre)
        begin
            rd_mux[7:0] = pre_cnt_ff;
        end
        else if (hit_tmr)
        begin
            rd_mux[7:0] = tmr_cnt_ff;
        end
    end

    // Register read data in setup phase
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rd_ff <= 32'h0000_0000;
        else if (setup)
            rd_ff <= rd_mux;
    end

    // Control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pll_ff <= PLLCON_RST;
            cpu_ff <= CPUMODE_RST;
        end
        else if (wr & hit_pll)
        begin
            pll_ff     <= pwdata[5:0];
            pll_ff.rsv <= 1'b0;
        end
        else if (wr & hit_cpu)
        begin
            cpu_ff     <= pwdata[7:0];
            cpu_ff.rsv <= 4'h0;
        end
    end

    // Pin synchroniser and edge history
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end
        else if (ce)
        begin
            s1_ff <= osc_in_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Oscillator enable; stop waits for phi high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_ff  <= 1'b1;
            osc_out_pin_ff <= 1'b1;
        end
        else if (ce)
        begin
            osc_ff  <= ~((st_ff == LP_STOP) & phi_ff);
            osc_out_pin_ff <= osc_ff ? ~s2_ff : 1'b1;
        end
    end

    // Reference half-period measure
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hp_cnt_ff <= 16'h0000;
            hp_len_ff <= 16'h0000;
        end
        else if (ce & ref_edge)
        begin
            hp_cnt_ff <= 16'h0000;
            hp_len_ff <= hp_cnt_ff + 16'h0001;
        end
        else if (ce & (hp_cnt_ff != 16'hFFFF))
            hp_cnt_ff <= hp_cnt_ff + 16'h0001;
    end

    // Synthesizer step generator, ref multiplied
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            vco_cnt_ff <= 16'h0000;
        else if (ce)
        begin
            if (!pll_act | vco_tick)
                vco_cnt_ff <= 16'h0000;
            else
                vco_cnt_ff <= vco_cnt_ff + 16'h0001;
        end
    end

    // Lock wait counter
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lock_cnt_ff <= '0;
        else if (ce)
        begin
            if (!pll_act)
                lock_cnt_ff <= '0;
            else if (lock_cnt_ff != LOCK_END)
                lock_cnt_ff <= lock_cnt_ff + LW'(1);
        end
    end

    // USB clock level, source selectable
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            usb_ff <= 1'b0;
        else if (ce & usb_tick)
            usb_ff <= ~usb_ff;
    end

    // Divided USB clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            syn_cnt_ff <= 4'h0;
            syn_ff     <= 1'b0;
        end
        else if (ce & usb_tick)
        begin
            if (syn_tick)
            begin
                syn_cnt_ff <= 4'h0;
                syn_ff     <= ~syn_ff;
            end
            else
                syn_cnt_ff <= syn_cnt_ff + 4'h1;
        end
    end

    // CPU clock divider; phi parks high when halted
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phi_cnt_ff <= 4'h0;
            phi_ff     <= 1'b1;
        end
        else if (ce & sys_tick)
        begin
            if (phi_step)
            begin
                phi_cnt_ff <= 4'h0;
                if (phi_tog)
                    phi_ff <= ~phi_ff;
            end
            else
                phi_cnt_ff <= phi_cnt_ff + 4'h1;
        end
    end

    // Settings taken only at start of a high half
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            src_act_ff <= CPUMODE_RST[0];
            phd_act_ff <= CPUMODE_RST[7:6];
            syd_act_ff <= PLLCON_RST[5:4];
        end
        else if (ce & phi_rise)
        begin
            src_act_ff <= cpu_ff.sys_src;
            phd_act_ff <= cpu_ff.phi_div;
            syd_act_ff <= pll_ff.syn_div;
        end
    end

    // Low-power state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= LP_RUN;
        else if (ce)
            st_ff <= nxt_st;
    end

    // Low-power transitions
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            LP_RUN:
            begin
                if (stop_instr)
                    nxt_st = LP_STOP;
                else if (wait_instr)
                    nxt_st = LP_WAIT;
            end
            LP_STOP:
            begin
                if (ext_irq)
                    nxt_st = LP_WAKE;
            end
            LP_WAKE:
            begin
                if (tmr_udf)
                    nxt_st = LP_RUN;
            end
            LP_WAIT:
            begin
                if (any_irq)
                    nxt_st = LP_RUN;
            end
            default:
                nxt_st = LP_RUN;
        endcase
    end

    // Reference over 16 for wake counting
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            w16_cnt_ff <= '0;
        else if (ce)
        begin
            if (st_ff != LP_WAKE)
                w16_cnt_ff <= '0;
            else if (ref_edge)
                w16_cnt_ff <= w16_cnt_ff + WW'(1);
        end
    end

    // Wake prescaler
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_cnt_ff <= PRE_STOP_VAL;
            pre_rld_ff <= PRE_STOP_VAL;
        end
        else if (ce)
        begin
            if (preload)
            begin
                pre_cnt_ff <= PRE_STOP_VAL;
                pre_rld_ff <= PRE_STOP_VAL;
            end
            else if (wake_cnt)
                pre_cnt_ff <= pre_zero ? pre_rld_ff : pre_cnt_ff - 8'h01;
            else if (wr & hit_pre)
            begin
                pre_cnt_ff <= pwdata[7:0];
                pre_rld_ff <= pwdata[7:0];
            end
        end
    end

    // Wake timer 1
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tmr_cnt_ff <= TMR_STOP_VAL;
        else if (ce)
        begin
            if (preload)
                tmr_cnt_ff <= TMR_STOP_VAL;
            else if (wake_cnt & pre_zero)
                tmr_cnt_ff <= tmr_cnt_ff - 8'h01;
            else if (wr & hit_tmr)
                tmr_cnt_ff <= pwdata[7:0];
        end
    end

    // Outputs
    assign prdata        = rd_ff;
    assign pready        = 1'b1;
    assign pslverr       = acc & ~hit;
    assign osc_out_pin   = osc_out_pin_ff;
    assign osc_run       = osc_ff;
    assign phi           = phi_ff;
    assign usb_func_clk  = usb_ff;
    assign syn_clk       = syn_ff;
    assign pll_locked    = (lock_cnt_ff == LOCK_END);
    assign pre_div16_sel = (st_ff == LP_STOP) | (st_ff == LP_WAKE);
    assign lp_state      = st_ff;

endmodule : pll_clock_select_low_power

/* File: test/pll_clk_checker.sv */
// Port checks for stop, wait and wake sequencing
`timescale 1ns/1ns
module pll_clk_checker
    import pll_clk_pkg::*;
(
    input wire logic      clk,           // Clock
    input wire logic      nrst,          // Reset, low
    input wire logic      ce,            // Clock enable
    input wire logic      osc_out_pin,   // Oscillator drive
    input wire logic      osc_run,       // Oscillator on
    input wire logic      stop_instr,    // Stop pulse
    input wire logic      wait_instr,    // Wait pulse
    input wire logic      ext_irq,       // Stop wake
    input wire logic      any_irq,       // Wait wake
    input wire logic      phi,           // CPU clock
    input wire logic      pre_div16_sel, // Slow prescaler feed
    input wire lp_state_t lp_state       // Power state
);
    // One clock domain throughout
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    chk_stop_entry: assert property (
        ce && stop_instr && lp_state == LP_RUN |=> lp_state == LP_STOP)
        else $error("stop not entered");
    chk_wait_entry: assert property (
        ce && wait_instr && !stop_instr && lp_state == LP_RUN |=> lp_state == LP_WAIT)
        else $error("wait not entered");
    chk_stop_osc_off: assert property (
        ce && lp_state == LP_STOP && phi && !ext_irq |=> !osc_run)
        else $error("oscillator kept running in stop");
    chk_stop_out_high: assert property (
        !osc_run && $past(osc_run) == 1'b0 |-> osc_out_pin)
        else $error("oscillator drive not parked");
    chk_slow_feed: assert property (
        pre_div16_sel == (lp_state == LP_STOP || lp_state == LP_WAKE))
        else $error("prescaler feed wrong");
    chk_wake_trigger: assert property (
        ce && lp_state == LP_STOP && ext_irq |=> lp_state == LP_WAKE ##2 osc_run)
        else $error("interrupt did not restart oscillator");
    chk_wake_phi_high: assert property (
        lp_state == LP_WAKE |-> phi)
        else $error("cpu clock supplied before underflow");
    chk_wait_osc_on: assert property (
        lp_state == LP_WAIT |-> osc_run)
        else $error("oscillator stopped in wait");
    chk_wait_phi_park: assert property (
        lp_state == LP_WAIT && phi && !any_irq |=> phi)
        else $error("cpu clock ran in wait");
    chk_wait_exit: assert property (
        ce && lp_state == LP_WAIT && any_irq |=> lp_state == LP_RUN)
        else $error("wait not left on interrupt");
endmodule : pll_clk_checker

bind pll_clock_select_low_power pll_clk_checker u_chk (
    .clk(clk), .nrst(nrst), .ce(ce), .osc_out_pin(osc_out_pin), .osc_run(osc_run),
    .stop_instr(stop_instr), .wait_instr(wait_instr), .ext_irq(ext_irq),
    .any_irq(any_irq), .phi(phi), .pre_div16_sel(pre_div16_sel), .lp_state(lp_state)
);

/* File: test/pll_clock_select_low_power_tb.sv */
// Self-checking bench for the clock select and low-power controller
`timescale 1ns/1ns
module pll_clock_select_low_power_tb;
    import pll_clk_pkg::*;
    localparam int LOCK = 50;     // Shortened lock wait
    localparam int LIMIT = 20000; // Cycle ceiling
    logic        clk = 1'b0;      // Clock
    logic        nrst = 1'b0;     // Reset, low
    logic        psel = 1'b0;     // APB select
    logic        penable = 1'b0;  // APB enable
    logic        pwrite = 1'b0;   // APB direction
    logic [11:0] paddr = 12'h000; // APB address
    logic [31:0] pwdata = 32'h0;  // APB write data
    logic        osc_in = 1'b0;   // Reference clock
    logic [3:0]  ev = 4'h0;       // Stop, wait, ext, any
    logic [31:0] prdata;          // Read data
    logic        pready;          // Ready
    logic        pslverr;         // Error
    logic        phi;             // CPU clock
    logic        usb_func_clk;    // USB clock
    logic        syn_clk;         // Divided clock
    logic        pll_locked;      // Lock flag
    logic        osc_run;         // Oscillator on
    logic        pre_div16_sel;   // Slow feed
    lp_state_t   lp_state;        // Power state
    int          num_errors = 0;  // Mismatches
    int          tests_run = 0;   // Comparisons
    int          cyc = 0;         // Cycle count
    int          ref_cnt = 0;     // Reference half period
    int          divs[4] = '{4, 6, 8, 2}; // Divided clock ratios
    logic [31:0] q;               // Read result
    logic        e;               // Error result

    pll_clock_select_low_power #(.LOCK_CYC(LOCK)) dut (
        .clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_in_pin(osc_in), .osc_out_pin(),
        .osc_run(osc_run), .stop_instr(ev[0]), .wait_instr(ev[1]), .ext_irq(ev[2]),
        .any_irq(ev[3]), .phi(phi), .usb_func_clk(usb_func_clk), .syn_clk(syn_clk),
        .pll_locked(pll_locked), .pre_div16_sel(pre_div16_sel), .lp_state(lp_state)
    );

    // 100 MHz clock
    always #5 clk = ~clk;

    // Crystal toggles every 4 cycles, only while enabled
    always @(posedge clk)
    begin
        ref_cnt <= (ref_cnt == 3) ? 0 : ref_cnt + 1;
        if (ref_cnt == 3 && osc_run === 1'b1)
            osc_in <= ~osc_in;
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            results();
        end
    end

    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer, then an idle cycle
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Read and compare
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp, "read");
    endtask : rd

    // One-cycle event pulse
    task pulse(input int w);
        ev[w] <= 1'b1;
        @(posedge clk);
        ev <= 4'h0;
        repeat (8) @(posedge clk);
    endtask : pulse

    // Period between the third and fourth rising edge
    task meas(input int s, input int exp);
        int k, r, t0;
        logic p, c;
        r = 0;
        t0 = 0;
        p = 1'b1;
        // New ratios take effect only at a CPU clock rise; let them settle
        repeat (100) @(posedge clk);
        for (k = 0; k < 800 && r < 4; k++)
        begin
            @(posedge clk);
            c = (s == 0) ? phi : (s == 1) ? syn_clk : usb_func_clk;
            if (c === 1'b1 && p === 1'b0)
            begin
                r++;
                if (r == 3)
                    t0 = k;
            end
            p = c;
        end
        chk(k - 1 - t0, exp, "period");
    endtask : meas

    // Verdict
    task results;
        $display("errors %0d tests %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        chk({phi, osc_run, lp_state, pll_locked, syn_clk}, 32'h30, "reset");
        nrst <= 1'b1;
        @(posedge clk);
        rd(12'h0E8, 32'h00);
        rd(12'h0F4, 32'hFF);
        rd(12'h0F8, 32'h01);
        apb(1'b1, 12'h0E8, 32'h3A);
        rd(12'h0E8, 32'h32);
        apb(1'b1, 12'h0EC, 32'hFC);
        rd(12'h0EC, 32'hC0);
        rd(12'h100, 32'h0);
        chk(e, 32'h1, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h0EC, {24'h0, 2'(i), 6'h0});
            meas(0, 8 << i);
        end
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h0E8, {26'h0, 2'(i), 4'h0});
            apb(1'b1, 12'h0EC, 32'h01);
            meas(1, 8 * divs[i]);
            meas(0, 8 * divs[i]);
        end
        apb(1'b1, 12'h0EC, 32'h00);
        apb(1'b1, 12'h0E8, 32'h01);
        repeat (LOCK + 20) @(posedge clk);
        chk(pll_locked, 1, "lock");
        apb(1'b1, 12'h0E8, 32'h05);
        meas(2, 2);
        apb(1'b1, 12'h0E8, 32'h00);
        // Lock counter clears one edge after the write lands
        @(posedge clk);
        chk(pll_locked, 0, "unlock");
        pulse(1);
        chk({lp_state, phi, osc_run}, {LP_WAIT, 2'b11}, "wait");
        pulse(3);
        chk(lp_state, LP_RUN, "wait exit");
        apb(1'b1, 12'h0F4, 32'h05);
        apb(1'b1, 12'h0F8, 32'h03);
        pulse(0);
        repeat (20) @(posedge clk);
        chk({lp_state, phi, osc_run, pre_div16_sel}, {LP_STOP, 3'b101}, "stop");
        rd(12'h0F4, 32'hFF);
        rd(12'h0F8, 32'h01);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({lp_state, osc_run}, {LP_RUN, 1'b1}, "reset exit");
        apb(1'b1, 12'h0EC, 32'h02);
        apb(1'b1, 12'h0F4, 32'h01);
        apb(1'b1, 12'h0F8, 32'h00);
        pulse(0);
        rd(12'h0F4, 32'h01);
        rd(12'h0F8, 32'h00);
        pulse(2);
        chk(lp_state, LP_WAKE, "wake");
        for (int i = 0; i < 3000 && lp_state !== LP_RUN; i++)
            @(posedge clk);
        chk(lp_state, LP_RUN, "wake done");
        results();
    end
endmodule : pll_clock_select_low_power_tb
